// ---- ipm_pkg.sv ----
// Constants and types of the interrupt and power mode controller.
// Assumes one oscillator clock; the core clock is a divided tick of it.
package ipm_pkg;

    // ****************************************
    // Sources and vectors
    // ****************************************
    localparam int NUM_SRC = 14;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_SRC0 = 16'hfffa;
    // Sources 2, 3, 4, 6 and 11 carry a peripheral status flag
    localparam logic [13:0] SRC_PERIPH_MASK = 14'h085c;
    localparam logic [13:0] SRC_HALT_WAKE = 14'h0003;
    localparam logic [3:0] SRC_NONE = 4'hf;

    // ****************************************
    // External sensitivity codes
    // ****************************************
    localparam logic [1:0] SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] SENS_RISE = 2'h1;
    localparam logic [1:0] SENS_FALL = 2'h2;
    localparam logic [1:0] SENS_BOTH = 2'h3;

    // ****************************************
    // Clocking and reset values
    // ****************************************
    localparam logic [2:0] DIV_SEL_RUN = 3'h0;
    localparam int STAB_CYCLES = 4096;
    localparam logic I_BIT_RESET = 1'b1;

    // ****************************************
    // Stacked items, in push order
    // ****************************************
    localparam logic [1:0] STACK_PC = 2'h0;
    localparam logic [1:0] STACK_X = 2'h1;
    localparam logic [1:0] STACK_A = 2'h2;
    localparam logic [1:0] STACK_CC = 2'h3;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_SLOW,
        MODE_WAIT,
        MODE_SLOW_WAIT,
        MODE_HALT
    } ipm_mode_type;

endpackage : ipm_pkg

// ---- ipm_ext_detect.sv ----
// One external interrupt group: pin combine, edge/level detect, request latch.
// Assumes pins already synchronous to the clock.
`timescale 1ns/10ps
module ipm_ext_detect
    import ipm_pkg::*;
#(
    parameter int PINS = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Pins and configuration
    input wire logic [PINS-1:0] pins_i,
    input wire logic [PINS-1:0] pin_int_en_i,
    input wire logic [1:0] sens_i,
    // Service entry and request
    input wire logic clear_i,
    output logic req_o
);

    typedef struct packed {
        logic src_prev;
        logic [1:0] sens_prev;
        logic latch;
    } ipm_ext_state_type;

    ipm_ext_state_type s_r;
    ipm_ext_state_type s_nxt;
    logic nand_out;
    logic src;
    logic edge_hit;

    // Disabled pins count as high so they never mask the group
    assign nand_out = ~&(pins_i | ~pin_int_en_i);
    assign src = ~nand_out;

    always_comb begin
        s_nxt = s_r;
        s_nxt.src_prev = src;
        s_nxt.sens_prev = sens_i;
        unique case (sens_i)
            SENS_RISE: edge_hit = src & ~s_r.src_prev;
            SENS_FALL: edge_hit = ~src & s_r.src_prev;
            SENS_BOTH: edge_hit = src ^ s_r.src_prev;
            SENS_FALL_LOW: edge_hit = ~src & s_r.src_prev;
        endcase
        // Changing sensitivity is the software way to drop a stale request
        if (clear_i || (sens_i != s_r.sens_prev)) begin
            s_nxt.latch = 1'b0;
        end
        if (edge_hit) begin
            s_nxt.latch = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{src_prev: 1'b1, sens_prev: SENS_FALL_LOW, latch: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Low level mode requests while low; its falling edge also sets the latch
    assign req_o = s_r.latch | ((sens_i == SENS_FALL_LOW) & ~s_r.src_prev);

endmodule : ipm_ext_detect

// ---- ipm_clk_div.sv ----
// Core clock divider: oscillator divided by 2, 4, 8, 16 or 32.
// Assumes sys_clk_i is the oscillator; tick_o marks each core cycle.
`timescale 1ns/10ps
module ipm_clk_div
    import ipm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic osc_en_i,
    input wire logic [2:0] div_sel_i,
    // Divided clock
    output logic tick_o,
    output logic clk_o
);

    typedef struct packed {
        logic [4:0] cnt;
        logic [2:0] sel;
        logic tick;
        logic clk;
    } ipm_div_state_type;

    ipm_div_state_type s_r;
    ipm_div_state_type s_nxt;
    logic [4:0] last;

    // Ratio is 2 shifted by the select; last count is ratio minus one
    assign last = 5'((6'h02 << s_r.sel) - 6'h01);

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (osc_en_i) begin
            if (s_r.cnt == last) begin
                s_nxt.cnt = 5'h00;
                s_nxt.tick = 1'b1;
                // New ratio only at a period end, so no short pulse
                s_nxt.sel = div_sel_i;
            end else begin
                s_nxt.cnt = 5'(s_r.cnt + 5'h01);
            end
            s_nxt.clk = (s_nxt.cnt <= (last >> 1));
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{cnt: 5'h00, sel: DIV_SEL_RUN, tick: 1'b0, clk: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;
    assign clk_o = s_r.clk;

endmodule : ipm_clk_div

// ---- ipm_ctrl.sv ----
// Interrupt and power mode controller top: request latching, fixed priority,
// service sequencing, WAIT/HALT/SLOW control.
// Assumes the CPU core reports instruction boundaries, executes stacking on
// request and acknowledges each pushed item; inputs are synchronous.
`timescale 1ns/10ps
module ipm_ctrl
    import ipm_pkg::*;
#(
    parameter int EXT0_PINS = 8,
    parameter int EXT1_PINS = 8,
    parameter int STAB_COUNT = STAB_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,

    // External group zero
    input wire logic [EXT0_PINS-1:0] ext0_pins_i,
    input wire logic [EXT0_PINS-1:0] ext0_int_en_i,
    input wire logic [1:0] ext0_sens_i,
    // External group one
    input wire logic [EXT1_PINS-1:0] ext1_pins_i,
    input wire logic [EXT1_PINS-1:0] ext1_int_en_i,
    input wire logic [1:0] ext1_sens_i,

    // Peripheral flags, enables and clear pulses, one bit per source
    input wire logic [NUM_SRC-1:0] periph_flag_i,
    input wire logic [NUM_SRC-1:0] periph_en_i,
    input wire logic [NUM_SRC-1:0] periph_clear_i,

    // Slow mode control
    input wire logic slow_mode_enable_i,
    input wire logic [1:0] prescale_select_i,

    // CPU instruction events
    input wire logic instr_end_i,
    input wire logic trap_exec_i,
    input wire logic wfi_exec_i,
    input wire logic halt_exec_i,
    input wire logic mask_set_i,
    input wire logic mask_clr_i,
    input wire logic return_from_interrupt_instruction_i,
    input wire logic return_from_interrupt_instruction_mask_i,

    // CPU stacking handshake
    output logic stack_push_o,
    output logic [1:0] stack_item_o,
    input wire logic stack_ack_i,

    // Vector and mask to the CPU
    output logic vector_load_o,
    output logic [15:0] vector_o,
    output logic mask_bit_o,

    // Clocking and mode
    output logic cpu_run_o,
    output logic cpu_tick_o,
    output logic periph_tick_o,
    output logic core_clock_o,
    output logic osc_enable_o,
    output ipm_mode_type mode_o
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT,
        ST_HALT,
        ST_STAB,
        ST_PUSH,
        ST_VECTOR
    } ipm_state_type;

    typedef struct packed {
        ipm_state_type state;
        logic [1:0] item;
        logic push;
        logic [15:0] vec_pend;
        logic [3:0] svc_src;
        logic [15:0] vec;
        logic vec_load;
        logic mask;
        logic [12:0] stab_cnt;
        logic [NUM_SRC-1:0] flag_prev;
        logic [NUM_SRC-1:0] plat;
        logic [1:0] ext_clr;
        logic run;
        logic cpu_tick;
        logic periph_tick;
        logic core_clk;
        logic osc_en;
        ipm_mode_type mode;
    } ipm_ctrl_state_type;

    ipm_ctrl_state_type s_r;
    ipm_ctrl_state_type s_nxt;

    logic [1:0] ext_req;
    logic div_tick;
    logic div_clk;
    logic [2:0] div_sel;

    // ****************************************
    // External groups and divider
    // ****************************************
    ipm_ext_detect #(
        .PINS(EXT0_PINS)
    ) u_ext0 (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .pins_i(ext0_pins_i),
        .pin_int_en_i(ext0_int_en_i),
        .sens_i(ext0_sens_i),
        .clear_i(s_r.ext_clr[0]),
        .req_o(ext_req[0])
    );

    ipm_ext_detect #(
        .PINS(EXT1_PINS)
    ) u_ext1 (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .pins_i(ext1_pins_i),
        .pin_int_en_i(ext1_int_en_i),
        .sens_i(ext1_sens_i),
        .clear_i(s_r.ext_clr[1]),
        .req_o(ext_req[1])
    );

    // Select 0 is the RUN ratio of two; 1 to 4 are the slow ratios
    assign div_sel = slow_mode_enable_i ? 3'({1'b0, prescale_select_i} + 3'h1) : DIV_SEL_RUN;

    ipm_clk_div u_div (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .osc_en_i(s_r.osc_en),
        .div_sel_i(div_sel),
        .tick_o(div_tick),
        .clk_o(div_clk)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [NUM_SRC-1:0] pending;
        logic [3:0] best;
        logic any_req;
        logic halt_wake;
        logic start_svc;
        logic [15:0] start_vec;
        logic [3:0] start_src;

        pending = '0;
        best = SRC_NONE;
        any_req = 1'b0;
        halt_wake = 1'b0;
        start_svc = 1'b0;
        start_vec = VEC_TRAP;
        start_src = SRC_NONE;
        s_nxt = s_r;
        s_nxt.vec_load = 1'b0;
        s_nxt.ext_clr = 2'h0;

        // Peripheral latch: new flag set wins over a clear in the same cycle
        s_nxt.flag_prev = periph_flag_i;
        s_nxt.plat = ((s_r.plat & ~periph_clear_i)
            | (periph_flag_i & ~s_r.flag_prev)) & SRC_PERIPH_MASK;

        pending = (s_r.plat & periph_en_i)
            | {{(NUM_SRC-2){1'b0}}, ext_req};
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (pending[k]) begin
                best = 4'(k);
            end
        end
        any_req = (best != SRC_NONE);
        halt_wake = |(pending & SRC_HALT_WAKE);

        // Mask bit updates from instructions
        if (mask_set_i) begin
            s_nxt.mask = 1'b1;
        end
        if (mask_clr_i) begin
            s_nxt.mask = 1'b0;
        end
        if (return_from_interrupt_instruction_i) begin
            s_nxt.mask = return_from_interrupt_instruction_mask_i;
        end

        unique case (s_r.state)
            ST_RUN: begin
                if (trap_exec_i) begin
                    start_svc = 1'b1;
                    start_vec = VEC_TRAP;
                end else if (instr_end_i && any_req && !s_r.mask) begin
                    start_svc = 1'b1;
                    start_src = best;
                end else if (wfi_exec_i) begin
                    s_nxt.state = ST_WAIT;
                    s_nxt.mask = 1'b0;
                end else if (halt_exec_i) begin
                    s_nxt.state = ST_HALT;
                    s_nxt.mask = 1'b0;
                end
            end

            ST_WAIT: begin
                // Mask is zero here, so any enabled request wakes
                if (any_req) begin
                    start_svc = 1'b1;
                    start_src = best;
                end
            end

            ST_HALT: begin
                // Oscillator is off; only the external groups can restart it
                if (halt_wake) begin
                    s_nxt.state = ST_STAB;
                    s_nxt.stab_cnt = '0;
                end
            end

            ST_STAB: begin
                // Counted in core cycles, so slow mode lengthens the delay
                if (div_tick) begin
                    if (s_r.stab_cnt == 13'(STAB_COUNT - 1)) begin
                        // Woken source may have gone away; then just resume
                        if (any_req) begin
                            start_svc = 1'b1;
                            start_src = best;
                        end else begin
                            s_nxt.state = ST_RUN;
                        end
                    end else begin
                        s_nxt.stab_cnt = 13'(s_r.stab_cnt + 13'h0001);
                    end
                end
            end

            ST_PUSH: begin
                // CPU paces the pushes; the item holds until acknowledged
                if (stack_ack_i) begin
                    if (s_r.item == STACK_CC) begin
                        s_nxt.mask = 1'b1;
                        s_nxt.state = ST_VECTOR;
                    end else begin
                        s_nxt.item = 2'(s_r.item + 2'h1);
                    end
                end
            end

            ST_VECTOR: begin
                // Edge latch clear lands one cycle after the vector load
                s_nxt.vec = s_r.vec_pend;
                s_nxt.vec_load = 1'b1;
                s_nxt.state = ST_RUN;
                if (s_r.svc_src == 4'h0) begin
                    s_nxt.ext_clr[0] = 1'b1;
                end
                if (s_r.svc_src == 4'h1) begin
                    s_nxt.ext_clr[1] = 1'b1;
                end
            end

            // Codes 6 and 7 are unused; recover to RUN rather than lock up
            default: begin
                s_nxt.state = ST_RUN;
            end
        endcase

        if (start_svc) begin
            if (start_src != SRC_NONE) begin
                start_vec = 16'(VEC_SRC0 - {11'h000, start_src, 1'b0});
            end
            s_nxt.state = ST_PUSH;
            s_nxt.item = STACK_PC;
            s_nxt.vec_pend = start_vec;
            s_nxt.svc_src = start_src;
        end

        // ****************************************
        // Clocking and mode outputs
        // ****************************************
        s_nxt.run = (s_nxt.state == ST_RUN);
        // Registered decode, so the push port comes straight from a flop
        s_nxt.push = (s_nxt.state == ST_PUSH);
        s_nxt.osc_en = (s_nxt.state != ST_HALT);
        s_nxt.cpu_tick = div_tick & (s_r.state != ST_WAIT) & (s_r.state != ST_HALT);
        s_nxt.periph_tick = div_tick & (s_r.state != ST_HALT);
        s_nxt.core_clk = div_clk;
        if (s_nxt.state == ST_HALT) begin
            s_nxt.mode = MODE_HALT;
        end else if (s_nxt.state == ST_WAIT) begin
            s_nxt.mode = slow_mode_enable_i ? MODE_SLOW_WAIT : MODE_WAIT;
        end else begin
            s_nxt.mode = slow_mode_enable_i ? MODE_SLOW : MODE_RUN;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Reset lands in the vector step with the reset vector pending
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{
                state: ST_VECTOR,
                item: STACK_PC,
                push: 1'b0,
                vec_pend: VEC_RESET,
                svc_src: SRC_NONE,
                vec: VEC_RESET,
                vec_load: 1'b0,
                mask: I_BIT_RESET,
                stab_cnt: 13'h0000,
                flag_prev: '0,
                plat: '0,
                ext_clr: 2'h0,
                run: 1'b0,
                cpu_tick: 1'b0,
                periph_tick: 1'b0,
                core_clk: 1'b0,
                osc_en: 1'b1,
                mode: MODE_RUN
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    assign stack_push_o = s_r.push;
    assign stack_item_o = s_r.item;
    assign vector_load_o = s_r.vec_load;
    assign vector_o = s_r.vec;
    assign mask_bit_o = s_r.mask;
    assign cpu_run_o = s_r.run;
    assign cpu_tick_o = s_r.cpu_tick;
    assign periph_tick_o = s_r.periph_tick;
    assign core_clock_o = s_r.core_clk;
    assign osc_enable_o = s_r.osc_en;
    assign mode_o = s_r.mode;

endmodule : ipm_ctrl

// ---- ipm_monitor.sv ----
// Concurrent checks on the interrupt and power mode controller ports.
// Assumes the bind below attaches it to every ipm_ctrl instance.
`timescale 1ns/10ps
module ipm_monitor
    import ipm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // CPU events and slow mode enable
    input wire logic trap_exec_i,
    input wire logic wfi_exec_i,
    input wire logic instr_end_i,
    input wire logic mask_set_i,
    input wire logic stack_ack_i,
    input wire logic slow_mode_enable_i,
    // Watched outputs
    input wire logic stack_push_o,
    input wire logic [1:0] stack_item_o,
    input wire logic vector_load_o,
    input wire logic mask_bit_o,
    input wire logic cpu_run_o,
    input wire logic cpu_tick_o,
    input wire logic periph_tick_o,
    input wire ipm_mode_type mode_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic in_wait;
    logic wfi_taken;
    assign in_wait = (mode_o == MODE_WAIT) || (mode_o == MODE_SLOW_WAIT);
    // Trap and a serviced instruction end outrank wait entry
    assign wfi_taken = wfi_exec_i && cpu_run_o && !trap_exec_i && !instr_end_i && !mask_set_i;

    // ****************************************
    // Service sequence
    // ****************************************
    property p_trap;
        trap_exec_i && cpu_run_o |=> stack_push_o && stack_item_o == STACK_PC && !cpu_run_o;
    endproperty
    a_trap: assert property (p_trap) else $error("trap did not start stacking");
    property p_item_adv;
        stack_push_o && stack_ack_i && stack_item_o != STACK_CC |=>
            stack_push_o && stack_item_o == $past(stack_item_o) + 2'h1;
    endproperty
    a_item_adv: assert property (p_item_adv) else $error("stack item order broken");
    property p_cc_end;
        stack_push_o && stack_ack_i && stack_item_o == STACK_CC |=> mask_bit_o && !stack_push_o ##1 vector_load_o;
    endproperty
    a_cc_end: assert property (p_cc_end) else $error("no masked vector after stacking");
    property p_load;
        vector_load_o |-> mask_bit_o && cpu_run_o;
    endproperty
    a_load: assert property (p_load) else $error("vector loaded unmasked or stopped");

    // ****************************************
    // Power modes and clocking
    // ****************************************
    property p_wfi;
        wfi_taken |=> !mask_bit_o && !cpu_run_o && in_wait;
    endproperty
    a_wfi: assert property (p_wfi) else $error("wait entry wrong");
    property p_slow_wait;
        wfi_taken && slow_mode_enable_i |=> mode_o == MODE_SLOW_WAIT;
    endproperty
    a_slow_wait: assert property (p_slow_wait) else $error("slow wait not entered");
    property p_wait_tick;
        in_wait [*2] |-> !cpu_tick_o;
    endproperty
    a_wait_tick: assert property (p_wait_tick) else $error("cpu ticking in wait");
    property p_tick2;
        (mode_o == MODE_RUN) [*4] ##0 periph_tick_o |=> !periph_tick_o ##1 (periph_tick_o || mode_o == MODE_HALT);
    endproperty
    a_tick2: assert property (p_tick2) else $error("run clock not divided by two");
endmodule : ipm_monitor

bind ipm_ctrl ipm_monitor i_ipm_monitor (
    .sys_clk_i, .reset_n_i, .trap_exec_i, .wfi_exec_i, .instr_end_i, .mask_set_i, .stack_ack_i,
    .slow_mode_enable_i, .stack_push_o, .stack_item_o, .vector_load_o, .mask_bit_o, .cpu_run_o,
    .cpu_tick_o, .periph_tick_o, .mode_o
);

// ---- ipm_cpu_model.sv ----
// CPU core model: acknowledges each stacked item after a settable delay.
// Assumes the controller holds push and item until acknowledged.
`timescale 1ns/10ps
module ipm_cpu_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Stacking handshake
    input wire logic stack_push_i,
    input wire logic [1:0] stack_item_i,
    output logic stack_ack_o,
    // Delay and log of the last four items
    input wire logic [2:0] ack_delay_i,
    output logic [7:0] push_log_o
);
    logic [2:0] wait_r;

    // Gap after each ack lets the item advance first
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_r <= 3'h0;
            stack_ack_o <= 1'b0;
            push_log_o <= 8'h00;
        end else if (stack_push_i && !stack_ack_o && wait_r >= ack_delay_i) begin
            stack_ack_o <= 1'b1;
            wait_r <= 3'h0;
            push_log_o <= {push_log_o[5:0], stack_item_i};
        end else begin
            stack_ack_o <= 1'b0;
            wait_r <= stack_push_i ? wait_r + 3'h1 : 3'h0;
        end
    end
endmodule : ipm_cpu_model

// ---- ipm_ctrl_tb.sv ----
// Self-checking bench for ipm_ctrl with a stacking CPU model.
// Assumes ipm_monitor is bound from its own file; stabilisation shortened to 8.
`timescale 1ns/10ps
module ipm_ctrl_tb
    import ipm_pkg::*;
;
    logic sys_clk, reset_n, none, instr_end, trap, wait_for_interrupt_instruction, halt, m_set, m_clr, return_from_interrupt_instruction, return_from_interrupt_instruction_mask, slow;
    logic push, ack, vload, mask, run, ctick, ptick, cclk, osc;
    logic [7:0] e0_pins, e0_en, e1_pins, e1_en, plog;
    logic [1:0] e0_sens, e1_sens, presc, item;
    logic [13:0] p_flag, p_en, p_clr;
    logic [15:0] vec;
    logic [2:0] ack_dly;
    ipm_mode_type mode;
    logic [15:0] exp_q[$];
    int miscompares, tests_run, loads, cycles;
    int srcs[5] = '{2, 3, 4, 6, 11};
    integer seed;

    ipm_ctrl #(.STAB_COUNT(8)) i_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .ext0_pins_i(e0_pins), .ext0_int_en_i(e0_en), .ext0_sens_i(e0_sens),
        .ext1_pins_i(e1_pins), .ext1_int_en_i(e1_en), .ext1_sens_i(e1_sens),
        .periph_flag_i(p_flag), .periph_en_i(p_en), .periph_clear_i(p_clr),
        .slow_mode_enable_i(slow), .prescale_select_i(presc),
        .instr_end_i(instr_end), .trap_exec_i(trap), .wfi_exec_i(wait_for_interrupt_instruction), .halt_exec_i(halt),
        .mask_set_i(m_set), .mask_clr_i(m_clr), .return_from_interrupt_instruction_i(return_from_interrupt_instruction), .return_from_interrupt_instruction_mask_i(return_from_interrupt_instruction_mask),
        .stack_push_o(push), .stack_item_o(item), .stack_ack_i(ack),
        .vector_load_o(vload), .vector_o(vec), .mask_bit_o(mask), .cpu_run_o(run), .cpu_tick_o(ctick),
        .periph_tick_o(ptick), .core_clock_o(cclk), .osc_enable_o(osc), .mode_o(mode)
    );
    ipm_cpu_model i_cpu (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .stack_push_i(push), .stack_item_i(item),
        .stack_ack_o(ack), .ack_delay_i(ack_dly), .push_log_o(plog)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Vectors are compared in load order against the driver's notes
    always @(negedge sys_clk) begin
        if (vload === 1'b1) begin
            loads++;
            check("vector", exp_q.size() != 0 ? exp_q.pop_front() : 16'h0000, vec);
            if (vec !== VEC_RESET) check("stack_order", 16'h001b, {8'h00, plog});
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    // ****************************************
    // Drivers, all at the falling edge
    // ****************************************
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    // A zero vector means nothing may be serviced in the window
    task automatic serve(ref logic ev, input logic [15:0] v, input logic [13:0] clr);
        int n0;
        n0 = loads;
        if (v != 16'h0000) exp_q.push_back(v);
        ack_dly = 3'($random(seed));
        for (int i = 0; i < 100 && run !== 1'b1; i++) cyc(1);
        pulse(ev);
        for (int i = 0; i < 60 && loads == n0; i++) cyc(1);
        if (v != 16'h0000) begin
            check("vector_taken", 16'h0001, 16'(loads - n0));
            p_clr = clr;
            cyc(1);
            p_clr = '0;
            pulse(return_from_interrupt_instruction);
        end
    endtask : serve

    task automatic period(input logic [15:0] exp);
        int k;
        int hi;
        for (int i = 0; i < 200 && ptick !== 1'b1; i++) cyc(1);
        cyc(1);
        hi = int'(cclk === 1'b1);
        for (k = 1; k < 100 && ptick !== 1'b1; k++) begin
            cyc(1);
            hi += int'(cclk === 1'b1);
        end
        check("tick_period", exp, 16'(k));
        check("clock_high", exp >> 1, 16'(hi));
    endtask : period

    initial begin
        seed = 32'h355d91c7;
        reset_n = 1'b0;
        {none, instr_end, trap, wait_for_interrupt_instruction, halt, m_set, m_clr, return_from_interrupt_instruction, return_from_interrupt_instruction_mask, slow} = '0;
        {p_flag, p_en, p_clr, presc, ack_dly} = '0;
        {e0_en, e0_pins, e0_sens} = {8'h81, 8'hff, SENS_FALL};
        {e1_en, e1_pins, e1_sens} = {8'h03, 8'h00, SENS_RISE};
        exp_q.push_back(VEC_RESET);
        cyc(5);
        reset_n = 1'b1;
        cyc(2);
        check("mode_reset", 16'(MODE_RUN), 16'(mode));
        serve(trap, VEC_TRAP, '0);
        pulse(m_set);
        e0_pins = 8'($random(seed)) | 8'h81;
        cyc(2);
        e0_pins[7] = 1'b0;
        cyc(3);
        serve(instr_end, 16'h0000, '0);
        pulse(m_clr);
        serve(instr_end, VEC_SRC0, '0);
        serve(instr_end, 16'h0000, '0);
        e1_pins = 8'h02;
        cyc(3);
        serve(instr_end, 16'h0000, '0);
        e1_pins = 8'h03;
        cyc(3);
        serve(instr_end, 16'hfff8, '0);
        foreach (srcs[j]) begin
            p_flag[srcs[j]] = 1'b1;
            cyc(2);
            serve(instr_end, 16'h0000, '0);
            p_en[srcs[j]] = 1'b1;
            serve(instr_end, VEC_SRC0 - 16'(2 * srcs[j]), 14'h0001 << srcs[j]);
            {p_flag, p_en} = '0;
            cyc(1);
        end
        p_flag[4] = 1'b1;
        cyc(2);
        p_clr = 14'h0010;
        cyc(1);
        p_clr = '0;
        p_en[4] = 1'b1;
        serve(instr_end, 16'h0000, '0);
        pulse(m_set);
        {p_flag, p_en} = {14'h0044, 14'h0044};
        cyc(2);
        serve(instr_end, 16'h0000, '0);
        pulse(m_clr);
        serve(instr_end, 16'hfff6, 14'h0004);
        serve(instr_end, 16'hffee, 14'h0040);
        {p_flag, p_en} = '0;
        slow = 1'b1;
        for (int c = 0; c < 4; c++) begin
            presc = 2'(c);
            cyc(70);
            period(16'(4 << c));
        end
        slow = 1'b0;
        cyc(70);
        period(16'h0002);
        slow = 1'b1;
        presc = 2'($random(seed));
        cyc(70);
        pulse(m_set);
        pulse(wait_for_interrupt_instruction);
        cyc(1);
        check("wait_mode", 16'(MODE_SLOW_WAIT), 16'(mode));
        check("wait_mask", 16'h0000, 16'(mask));
        period(16'(4 << presc));
        {p_en[3], p_flag[3]} = 2'h3;
        serve(none, 16'hfff4, 14'h0008);
        {p_flag, p_en, slow} = '0;
        cyc(70);
        pulse(halt);
        {p_en[6], p_flag[6]} = 2'h3;
        cyc(30);
        check("halt_mode", 16'(MODE_HALT), 16'(mode));
        check("halt_osc", 16'h0000, 16'(osc));
        e1_pins = 8'h01;
        cyc(2);
        e1_pins = 8'h03;
        cyc(6);
        check("halt_stab", 16'h0000, 16'(run));
        serve(none, 16'hfff8, 14'h0040);
        results();
    end
endmodule : ipm_ctrl_tb
